/* clkgen_pkg.sv */
`default_nettype none
package clkgen_pkg;
  localparam int         NUM_STORED     = 7;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h00;
  localparam logic [7:0] ADDR_FB_ONE    = 8'h01;
  localparam logic [7:0] ADDR_FB_TWO    = 8'h02;
  localparam logic [7:0] ADDR_OUT_A     = 8'h03;
  localparam logic [7:0] ADDR_OUT_B     = 8'h04;
  localparam logic [7:0] ADDR_CTRL_A    = 8'h05;
  localparam logic [7:0] ADDR_CTRL_B    = 8'h06;
  localparam logic [7:0] ADDR_STATUS    = 8'h07;
  localparam logic [7:0] ADDR_LAST      = 8'h08;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] CTRL_A_RESET   = 8'h60;
  localparam logic [7:0] MASK_FULL      = 8'hFF;
  localparam logic [7:0] MASK_FB_TWO    = 8'hFE;
  localparam logic [7:0] MASK_OUT_DIV   = 8'hE0;
  localparam logic [7:0] MASK_CTRL_A    = 8'hFE;
  localparam logic [7:0] MASK_CTRL_B    = 8'hE6;
  localparam int BIT_OUT_DISABLE = 7;
  localparam int BIT_EN_A        = 6;
  localparam int BIT_EN_B        = 5;
  localparam int BIT_DEFAULT_IN  = 4;
  localparam int BIT_IN_EN_HI    = 3;
  localparam int BIT_IN_EN_LO    = 2;
  localparam int BIT_REVERT      = 1;
  localparam int BIT_MON_RESET   = 0;
  localparam int BIT_HOLD_EN     = 7;
  localparam int BIT_FORCE_HOLD  = 6;
  localparam int BIT_ACQ_NOM     = 5;
  localparam int BIT_SOFT_RESET  = 4;
  localparam int BIT_ROUTE_SEL   = 2;
  localparam int BIT_ACQ_SEL     = 1;
  localparam int RATIO_MSB       = 7;
  localparam int RATIO_LSB       = 5;
  localparam logic [1:0] IN_EN_PINS   = 2'h0;
  localparam logic [1:0] IN_EN_ONLY_A = 2'h1;
  localparam logic [1:0] IN_EN_ONLY_B = 2'h2;
  localparam logic [1:0] STRAP_HIGH   = 2'h2;
  localparam logic [3:0] STRAP_LEVELS = 4'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [6:0] DEV_ADDR_BASE = 7'h68;
  localparam logic [2:0] RATIO_CODE_EIGHT = 3'h6;
  localparam logic [2:0] RATIO_CODE_SIXTEEN = 3'h7;
  localparam logic [4:0] RATIO_EIGHT   = 5'h08;
  localparam logic [4:0] RATIO_SIXTEEN = 5'h10;
  localparam logic [4:0] RATIO_RESET   = 5'h01;
  localparam logic [8:0] PRESC_RESET   = 9'h001;
  localparam logic [15:0] FB_RESET     = 16'h0001;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [4:0] SPI_WORD_BITS = 5'h10;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_RD_GO
  } serial_state_t;
endpackage
`default_nettype wire

/* spi_word_rx.sv */
`default_nettype none
module spi_word_rx (
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire logic       enable_in,
  input  wire logic       cs_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            word_valid_out,
  output logic [6:0]      word_addr_out,
  output logic [7:0]      word_data_out
);
  import clkgen_pkg::*;
  typedef struct packed {
    logic        cs_n;
    logic        scl;
    logic [15:0] shift;
    logic [4:0]  count;
    logic        valid;
    logic [6:0]  addr;
    logic [7:0]  data;
  } rx_t;
  rx_t rx_q, rx_d;

  always_comb begin
    rx_d       = rx_q;
    rx_d.cs_n  = cs_n_in;
    rx_d.scl   = scl_in;
    rx_d.valid = 1'b0;
    if (cs_n_in) begin
      // a word counts only when select rises after at least 16 bits; clocks after the sixteenth are ignored
      if (!rx_q.cs_n && rx_q.count == SPI_WORD_BITS && !rx_q.shift[15]
          && enable_in) begin
        rx_d.valid = 1'b1;
        rx_d.addr  = rx_q.shift[14:8];
        rx_d.data  = rx_q.shift[7:0];
      end
      rx_d.count = '0;
    end else if (scl_in && !rx_q.scl && rx_q.count != SPI_WORD_BITS) begin
      rx_d.shift = {rx_q.shift[14:0], sda_in};
      rx_d.count = rx_q.count + 5'h01;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_q      <= '0;
      rx_q.cs_n <= 1'b1;
    end else begin
      rx_q <= rx_d;
    end
  end

  assign word_valid_out = rx_q.valid;
  assign word_addr_out  = rx_q.addr;
  assign word_data_out  = rx_q.data;
endmodule // spi_word_rx
`default_nettype wire

/* clock_gen_config_registers.sv */
// Summary of operation
// - straps give address, both high select three-wire
// - nine byte registers at addresses zero to eight
// - three-wire address uses seven low bits
// - prescaler divides by code plus one
// - feedback code fifteen bits, divides code plus one
// - output ratio from top three bits
// - output disable forces clock outputs low
// - per-output enable zero gives high impedance
// - default input bit picks first or second
// - input enable field, zero defers to pins
// - revert bit enables revertive switching
// - monitor reset in revert clears interrupt flag
// - holdover enable bit permits holdover
// - forced holdover; rising edge captures nominal
// - acquire bit rising edge captures nominal
// - software reset bit equals reset pin
// - route select picks divider for third output
// - acquire select holds crystal at captured value
// - status shows input failures and input used
// - status shows unlock and holdover state
// - power-up values zero, control one 0x60
// - three-wire sixteen-bit words, MSB first
// - two-wire write advances pointer per byte
// - two-wire read streams through last register
`default_nettype none
module clock_gen_config_registers (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic [1:0]  addr_strap_zero_in,
  input  wire logic [1:0]  addr_strap_one_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        cs_n_in,
  input  wire logic        master_reset_pin_in,
  input  wire logic        input_select_pin_a_in,
  input  wire logic        input_select_pin_b_in,
  input  wire logic        ref_fail_a_in,
  input  wire logic        ref_fail_b_in,
  input  wire logic        ref_in_use_in,
  input  wire logic        pll_unlocked_in,
  input  wire logic        holdover_active_in,
  input  wire logic        monitor_event_in,
  output logic [8:0]       prescale_ratio_out,
  output logic [15:0]      feedback_ratio_out,
  output logic [4:0]       out_ratio_a_out,
  output logic [4:0]       out_ratio_b_out,
  output logic             clock_out_a_oe_out,
  output logic             clock_out_b_oe_out,
  output logic             clock_out_force_low_out,
  output logic             divider_route_select_out,
  output logic             default_input_out,
  output logic [1:0]       ref_input_enable_out,
  output logic             revert_enable_out,
  output logic             monitor_reset_out,
  output logic             int_out,
  output logic             holdover_enable_out,
  output logic             forced_holdover_out,
  output logic             acquire_nominal_out,
  output logic             acquire_select_out,
  output logic             chip_reset_out
);
  import clkgen_pkg::*;

  localparam int SYNC_W = 15;
  localparam int S_AD0 = 0;
  localparam int S_AD1 = 2;
  localparam int S_SCL = 4;
  localparam int S_SDA = 5;
  localparam int S_CS  = 6;
  localparam int S_MR  = 7;
  localparam int S_SLA = 8;
  localparam int S_SLB = 9;
  localparam int S_FA  = 10;
  localparam int S_FB  = 11;
  localparam int S_USE = 12;
  localparam int S_UNL = 13;
  localparam int S_HLD = 14;

  typedef struct packed {
    logic [SYNC_W-1:0]           s1;
    logic [SYNC_W-1:0]           s2;
    logic                        mon1;
    logic                        mon2;
    logic                        mon_prev;
    logic                        scl_prev;
    logic                        sda_prev;
    logic [1:0]                  strap_cnt;
    logic                        strap_done;
    logic                        spi_mode;
    logic [6:0]                  dev_addr;
    serial_state_t               state;
    logic [2:0]                  bits;
    logic                        full;
    logic [7:0]                  shift;
    logic                        rw;
    logic [7:0]                  ptr;
    logic                        sda_oe;
    logic [NUM_STORED-1:0][7:0]  regs;
    logic                        int_flag;
    logic [7:0]                  status;
    logic [8:0]                  presc;
    logic [15:0]                 fb;
    logic [4:0]                  ratio_a;
    logic [4:0]                  ratio_b;
    logic [1:0]                  ref_en;
    logic                        mon_rst;
    logic                        acq;
    logic                        chip_rst;
  } state_t;

  state_t     st_q, st_d;
  logic       spi_valid;
  logic [6:0] spi_addr;
  logic [7:0] spi_data;

  spi_word_rx u_spi (
    .clock_in       (clock_in),
    .nrst_in        (nrst_in),
    .enable_in      (st_q.spi_mode),
    .cs_n_in        (st_q.s2[S_CS]),
    .scl_in         (st_q.s2[S_SCL]),
    .sda_in         (st_q.s2[S_SDA]),
    .word_valid_out (spi_valid),
    .word_addr_out  (spi_addr),
    .word_data_out  (spi_data)
  );

  // reserved bits never store, so they read back as zero
  function automatic logic [7:0] write_mask(input logic [7:0] a);
    case (a)
      ADDR_FB_TWO:             write_mask = MASK_FB_TWO;
      ADDR_OUT_A, ADDR_OUT_B:  write_mask = MASK_OUT_DIV;
      ADDR_CTRL_A:             write_mask = MASK_CTRL_A;
      ADDR_CTRL_B:             write_mask = MASK_CTRL_B;
      default:                 write_mask = MASK_FULL;
    endcase
  endfunction

  function automatic logic [4:0] ratio(input logic [7:0] r);
    logic [2:0] c;
    c = r[RATIO_MSB:RATIO_LSB];
    if (c == RATIO_CODE_SIXTEEN)    ratio = RATIO_SIXTEEN;
    else if (c == RATIO_CODE_EIGHT) ratio = RATIO_EIGHT;
    else                            ratio = {2'b00, c} + RATIO_RESET;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input state_t s);
    if (a < ADDR_STATUS)       rd_byte = s.regs[a[2:0]];
    else if (a == ADDR_STATUS) rd_byte = s.status;
    else                       rd_byte = REG_RESET;
  endfunction

  always_comb begin
    logic       scl;
    logic       sda;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] ptr_next;
    logic [3:0] idx;
    scl      = st_q.s2[S_SCL];
    sda      = st_q.s2[S_SDA];
    wr_en    = 1'b0;
    wr_addr  = REG_RESET;
    wr_data  = REG_RESET;
    ptr_next = (st_q.ptr >= ADDR_LAST) ? st_q.ptr : st_q.ptr + 8'h01;
    idx      = {2'b00, st_q.s2[S_AD0+:2]} * STRAP_LEVELS
               + {2'b00, st_q.s2[S_AD1+:2]};
    st_d     = st_q;
    st_d.s1  = {holdover_active_in, pll_unlocked_in, ref_in_use_in,
                ref_fail_b_in, ref_fail_a_in, input_select_pin_b_in,
                input_select_pin_a_in, master_reset_pin_in, cs_n_in,
                sda_in, scl_in, addr_strap_one_in, addr_strap_zero_in};
    st_d.s2       = st_q.s1;
    st_d.mon1     = monitor_event_in;
    st_d.mon2     = st_q.mon1;
    st_d.mon_prev = st_q.mon2;
    st_d.scl_prev = scl;
    st_d.sda_prev = sda;
    st_d.mon_rst  = 1'b0;
    st_d.acq      = 1'b0;
    // straps are taken once, after the synchroniser has filled
    if (!st_q.strap_done) begin
      st_d.strap_cnt = st_q.strap_cnt + 2'h1;
      if (st_q.strap_cnt == STRAP_SETTLE) begin
        st_d.strap_done = 1'b1;
        st_d.spi_mode   = st_q.s2[S_AD0+:2] == STRAP_HIGH
                          && st_q.s2[S_AD1+:2] == STRAP_HIGH;
        st_d.dev_addr   = DEV_ADDR_BASE + {3'b000, idx};
      end
    end
    if (!st_q.strap_done || st_q.spi_mode) begin
      st_d.state  = ST_IDLE;
      st_d.sda_oe = 1'b0;
    end else if (scl && st_q.scl_prev && st_q.sda_prev && !sda) begin
      st_d.state  = ST_ADDR;
      st_d.bits   = '0;
      st_d.full   = 1'b0;
      st_d.sda_oe = 1'b0;
    end else if (scl && st_q.scl_prev && !st_q.sda_prev && sda) begin
      st_d.state  = ST_IDLE;
      st_d.sda_oe = 1'b0;
    end else if (scl && !st_q.scl_prev) begin
      case (st_q.state)
        ST_ADDR, ST_PTR, ST_WR, ST_RD: begin
          st_d.bits = st_q.bits + 3'h1;
          st_d.full = st_q.bits == BYTE_LAST_BIT;
          if (st_q.state != ST_RD) st_d.shift = {st_q.shift[6:0], sda};
        end
        ST_RD_ACK: begin
          if (sda) begin
            st_d.state = ST_IDLE;
          end else begin
            st_d.ptr   = ptr_next;
            st_d.shift = rd_byte(ptr_next, st_q);
            st_d.state = ST_RD_GO;
          end
        end
        default: ;
      endcase
    end else if (!scl && st_q.scl_prev) begin
      case (st_q.state)
        ST_ADDR: begin
          if (st_q.full) begin
            st_d.full = 1'b0;
            if (st_q.shift[7:1] == st_q.dev_addr) begin
              st_d.sda_oe = 1'b1;
              st_d.rw     = st_q.shift[0];
              st_d.state  = ST_ADDR_ACK;
            end else begin
              st_d.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (st_q.rw) begin
            st_d.shift  = rd_byte(st_q.ptr, st_q);
            st_d.sda_oe = ~st_d.shift[7];
            st_d.state  = ST_RD;
          end else begin
            st_d.sda_oe = 1'b0;
            st_d.state  = ST_PTR;
          end
        end
        ST_PTR: begin
          if (st_q.full) begin
            st_d.full   = 1'b0;
            st_d.ptr    = st_q.shift;
            st_d.sda_oe = 1'b1;
            st_d.state  = ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          st_d.sda_oe = 1'b0;
          st_d.state  = ST_WR;
        end
        ST_WR: begin
          if (st_q.full) begin
            st_d.full   = 1'b0;
            wr_en       = 1'b1;
            wr_addr     = st_q.ptr;
            wr_data     = st_q.shift;
            st_d.ptr    = st_q.ptr + 8'h01;
            st_d.sda_oe = 1'b1;
            st_d.state  = ST_WR_ACK;
          end
        end
        ST_RD: begin
          if (st_q.full) begin
            st_d.full   = 1'b0;
            st_d.sda_oe = 1'b0;
            st_d.state  = ST_RD_ACK;
          end else begin
            st_d.shift  = {st_q.shift[6:0], 1'b0};
            st_d.sda_oe = ~st_q.shift[6];
          end
        end
        ST_RD_GO: begin
          st_d.sda_oe = ~st_q.shift[7];
          st_d.state  = ST_RD;
        end
        default: ;
      endcase
    end
    if (spi_valid) begin
      wr_en   = 1'b1;
      wr_addr = {1'b0, spi_addr};
      wr_data = spi_data;
    end
    // status, spare and out-of-range addresses swallow writes
    if (wr_en && wr_addr < ADDR_STATUS) begin
      st_d.regs[wr_addr[2:0]] = wr_data & write_mask(wr_addr);
      if (wr_addr == ADDR_CTRL_A && wr_data[BIT_MON_RESET]
          && wr_data[BIT_REVERT]) begin
        st_d.mon_rst = 1'b1;
      end
      if (wr_addr == ADDR_CTRL_B) begin
        st_d.acq = (wr_data[BIT_ACQ_NOM]
                    && !st_q.regs[ADDR_CTRL_B][BIT_ACQ_NOM])
                   || (wr_data[BIT_FORCE_HOLD]
                    && !st_q.regs[ADDR_CTRL_B][BIT_FORCE_HOLD]);
      end
    end
    // a new failure event beats a simultaneous monitor reset
    if (st_q.mon2 && !st_q.mon_prev) st_d.int_flag = 1'b1;
    else if (st_d.mon_rst)           st_d.int_flag = 1'b0;
    st_d.chip_rst = st_q.s2[S_MR] || (wr_en && wr_addr == ADDR_CTRL_B
                    && wr_data[BIT_SOFT_RESET]);
    if (st_d.chip_rst) begin
      st_d.regs              = '0;
      st_d.regs[ADDR_CTRL_A] = CTRL_A_RESET;
      st_d.int_flag          = 1'b0;
      st_d.mon_rst           = 1'b0;
      st_d.acq               = 1'b0;
      st_d.state             = ST_IDLE;
      st_d.sda_oe            = 1'b0;
    end
    st_d.status = {st_d.int_flag, st_q.s2[S_FA], st_q.s2[S_FB],
                   st_q.s2[S_USE], st_q.s2[S_UNL], st_q.s2[S_HLD],
                   2'b00};
    st_d.presc   = {1'b0, st_d.regs[ADDR_PRESCALE]} + PRESC_RESET;
    st_d.fb      = {1'b0, st_d.regs[ADDR_FB_ONE],
                    st_d.regs[ADDR_FB_TWO][7:1]} + FB_RESET;
    st_d.ratio_a = ratio(st_d.regs[ADDR_OUT_A]);
    st_d.ratio_b = ratio(st_d.regs[ADDR_OUT_B]);
    case (st_d.regs[ADDR_CTRL_A][BIT_IN_EN_HI:BIT_IN_EN_LO])
      IN_EN_PINS:   st_d.ref_en = {st_q.s2[S_SLB], st_q.s2[S_SLA]};
      IN_EN_ONLY_A: st_d.ref_en = 2'b01;
      IN_EN_ONLY_B: st_d.ref_en = 2'b10;
      default:      st_d.ref_en = 2'b11;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q                   <= '0;
      st_q.regs[ADDR_CTRL_A] <= CTRL_A_RESET;
      st_q.presc             <= PRESC_RESET;
      st_q.fb                <= FB_RESET;
      st_q.ratio_a           <= RATIO_RESET;
      st_q.ratio_b           <= RATIO_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // open-drain line: only the enable ever moves
  assign sda_out                  = 1'b0;
  assign sda_oe_out               = st_q.sda_oe;
  assign prescale_ratio_out       = st_q.presc;
  assign feedback_ratio_out       = st_q.fb;
  assign out_ratio_a_out          = st_q.ratio_a;
  assign out_ratio_b_out          = st_q.ratio_b;
  assign clock_out_a_oe_out       = st_q.regs[ADDR_CTRL_A][BIT_EN_A];
  assign clock_out_b_oe_out       = st_q.regs[ADDR_CTRL_A][BIT_EN_B];
  assign clock_out_force_low_out  =
    st_q.regs[ADDR_CTRL_A][BIT_OUT_DISABLE];
  assign divider_route_select_out =
    st_q.regs[ADDR_CTRL_B][BIT_ROUTE_SEL];
  assign default_input_out   = st_q.regs[ADDR_CTRL_A][BIT_DEFAULT_IN];
  assign ref_input_enable_out = st_q.ref_en;
  assign revert_enable_out   = st_q.regs[ADDR_CTRL_A][BIT_REVERT];
  assign monitor_reset_out   = st_q.mon_rst;
  assign int_out             = st_q.int_flag;
  assign holdover_enable_out = st_q.regs[ADDR_CTRL_B][BIT_HOLD_EN];
  assign forced_holdover_out =
    st_q.regs[ADDR_CTRL_B][BIT_FORCE_HOLD];
  assign acquire_nominal_out = st_q.acq;
  assign acquire_select_out  = st_q.regs[ADDR_CTRL_B][BIT_ACQ_SEL];
  assign chip_reset_out      = st_q.chip_rst;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence wr_byte_done;
    st_q.state == ST_WR ##1 st_q.state == ST_WR_ACK;
  endsequence
  AST_SPI_NO_ACK: assert property (
    st_q.spi_mode |-> !sda_oe_out)
    else $error("two-wire port answered in three-wire mode");
  AST_PTR_STEP: assert property (
    wr_byte_done |-> st_q.ptr == $past(st_q.ptr) + 8'h01)
    else $error("pointer did not advance after a data byte");
  AST_PRESCALE: assert property (
    $changed(st_q.regs[ADDR_PRESCALE]) |->
      prescale_ratio_out == {1'b0, st_q.regs[ADDR_PRESCALE]} + 9'h001)
    else $error("prescale ratio not code plus one");
  AST_RATIO_TOP: assert property (
    st_q.regs[ADDR_OUT_A][7:5] == 3'h7 |-> out_ratio_a_out == 5'h10)
    else $error("top output code must give sixteen");
  AST_RESERVED: assert property (
    st_q.regs[ADDR_OUT_B][4:0] == 5'h00
      && st_q.regs[ADDR_FB_TWO][0] == 1'b0)
    else $error("reserved bit stored");
  AST_MON_CLEAR: assert property (
    monitor_reset_out && !$past(st_q.mon2) |-> !int_out)
    else $error("monitor reset left interrupt set");
  AST_ACQ_EDGE: assert property (
    $rose(st_q.regs[ADDR_CTRL_B][BIT_ACQ_NOM]) && !chip_reset_out
      |-> acquire_nominal_out ##1 !acquire_nominal_out)
    else $error("acquire edge not a single pulse");
  AST_SOFT_RESET: assert property (
    chip_reset_out |-> st_q.regs[ADDR_CTRL_A] == 8'h60
      && st_q.regs[ADDR_PRESCALE] == 8'h00)
    else $error("chip reset did not restore defaults");
  AST_IN_ONLY_B: assert property (
    st_q.regs[ADDR_CTRL_A][3:2] == 2'h2 |->
      ref_input_enable_out == 2'b10)
    else $error("input enable field not honoured");
endmodule // clock_gen_config_registers
`default_nettype wire

/* serial_host.sv */
`default_nettype none
module serial_host (
  input  wire logic clock_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_low_out,
  output var logic  cs_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {scl_out, sda_low_out, cs_n_out} = 3'b101;
  task automatic tk(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // sda moves only mid-low, so the slow synchroniser never sees a false stop
  task automatic bt(input logic b, output logic r);
    tk(6);
    sda_low_out <= !b;
    tk(6);
    scl_out <= 1'b1;
    tk(8);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  // s low gives start, s high gives stop
  task automatic cond(input logic s);
    tk(6);
    sda_low_out <= s;
    tk(6);
    scl_out <= 1'b1;
    tk(8);
    sda_low_out <= !s;
    tk(8);
    if (!s) scl_out <= 1'b0;
  endtask
  task automatic wb(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(b[i], r);
    bt(1'b1, r);
    ack = !r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] p,
                    input logic [7:0] d[$], output logic ack);
    logic a;
    cond(1'b0);
    wb({dev, 1'b0}, ack);
    wb(p, a);
    foreach (d[i]) wb(d[i], a);
    cond(1'b1);
  endtask
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [7:0] q[$]);
    logic a;
    logic [7:0] b;
    q = {};
    cond(1'b0);
    wb(8'hD0, a);
    wb(p, a);
    cond(1'b0);
    wb(8'hD1, a);
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) bt(1'b1, b[j]);
      bt(i == n - 1, a);
      q.push_back(b);
    end
    cond(1'b1);
  endtask
  // scl low before select, word clocked in msb first
  task automatic spi(input logic [15:0] wd);
    logic r;
    scl_out <= 1'b0;
    tk(8);
    cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) bt(wd[i], r);
    tk(8);
    cs_n_out <= 1'b1;
    tk(16);
  endtask
endmodule // serial_host
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic nrst_in, master_reset_pin_in, monitor_event_in;
  logic [1:0] addr_strap_zero_in, addr_strap_one_in, ref_input_enable_out;
  logic input_select_pin_a_in, input_select_pin_b_in, ref_fail_a_in;
  logic ref_fail_b_in, ref_in_use_in, pll_unlocked_in, holdover_active_in;
  wire logic scl_in, sda_in, cs_n_in, host_low;
  logic sda_out, sda_oe_out, clock_out_a_oe_out, clock_out_b_oe_out;
  logic clock_out_force_low_out, divider_route_select_out, int_out;
  logic default_input_out, revert_enable_out, monitor_reset_out;
  logic holdover_enable_out, forced_holdover_out, acquire_nominal_out;
  logic acquire_select_out, chip_reset_out, ack;
  logic [8:0] prescale_ratio_out;
  logic [15:0] feedback_ratio_out;
  logic [4:0] out_ratio_a_out, out_ratio_b_out;
  logic [4:0] rt[8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
                        5'h10};
  logic [14:0] ct[3] = '{{8'h9E, 7'h4F}, {8'hC4, 7'h62}, {8'h28, 7'h14}};
  int n_fail = 0, total_checks = 0, cycles = 0;
  int n_acq = 0, n_mon = 0, n_rst = 0;
  wire logic [6:0] ca = {clock_out_force_low_out, clock_out_a_oe_out,
    clock_out_b_oe_out, default_input_out, ref_input_enable_out,
    revert_enable_out};
  wire logic [3:0] cb = {holdover_enable_out, forced_holdover_out,
    divider_route_select_out, acquire_select_out};
  // open-drain line with pull-up
  assign sda_in = (sda_oe_out ? sda_out : 1'b1) & !host_low;
  always #4 clock_in = ~clock_in;
  clock_gen_config_registers i_clock_gen_config_registers (.*);
  serial_host i_serial_host (.clock_in, .sda_in, .scl_out(scl_in),
    .sda_low_out(host_low), .cs_n_out(cs_n_in));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] p, input int n,
                       input logic [71:0] e);
    logic [7:0] q[$];
    i_serial_host.rd(p, n, q);
    for (int i = 0; i < n; i++) chk(32'(q[i]), 32'(e[8*(n-1-i) +: 8]));
  endtask
  task automatic w(input logic [7:0] p, input logic [7:0] d[$]);
    i_serial_host.wr(7'h68, p, d, ack);
  endtask
  task automatic rst();
    nrst_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
  endtask
  // pulse outputs last one cycle when set by a register write, so they are counted every edge
  always @(negedge clock_in) begin
    cycles++;
    if (acquire_nominal_out === 1'b1) n_acq++;
    if (monitor_reset_out === 1'b1) n_mon++;
    if (chip_reset_out === 1'b1) n_rst++;
    if (cycles == 60000) begin
      $display("ERROR %0t run did not finish in time", $time);
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {nrst_in, master_reset_pin_in, monitor_event_in, ref_fail_a_in} = 4'h0;
    {ref_fail_b_in, ref_in_use_in, pll_unlocked_in} = 3'h0;
    {holdover_active_in, input_select_pin_a_in, input_select_pin_b_in} = 3'h0;
    {addr_strap_zero_in, addr_strap_one_in} = 4'h0;
    rst();
    rdchk(8'h00, 9, 72'h000000000060000000);
    chk(32'({prescale_ratio_out, feedback_ratio_out}), 32'h0010001);
    w(8'h00, '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hDF});
    chk(32'({prescale_ratio_out, feedback_ratio_out}), 32'h1008000);
    rdchk(8'h00, 5, 72'hFFFFFEE0C0);
    w(8'h00, '{8'h01, 8'h00, 8'h02});
    chk(32'({prescale_ratio_out, feedback_ratio_out}), 32'h0020002);
    for (int c = 0; c < 8; c++) begin
      w(8'h03, '{{3'(c), 5'h1F}});
      chk(32'(out_ratio_a_out), 32'(rt[c]));
    end
    for (int i = 0; i < 3; i++) begin
      w(8'h05, '{ct[i][14:7]});
      chk(32'(ca), 32'(ct[i][6:0]));
    end
    w(8'h06, '{8'hE6});
    chk(32'({cb, 4'(n_acq)}), 32'hF1);
    w(8'h06, '{8'h00});
    w(8'h06, '{8'h20});
    chk(32'({cb, 4'(n_acq)}), 32'h02);
    rdchk(8'h06, 1, 72'h20);
    {ref_fail_a_in, ref_in_use_in, pll_unlocked_in} <= 3'h7;
    {holdover_active_in, monitor_event_in} <= 2'h3;
    rdchk(8'h07, 1, 72'hDC);
    chk(32'(int_out), 32'h1);
    monitor_event_in <= 1'b0;
    {input_select_pin_b_in, input_select_pin_a_in} <= 2'h2;
    w(8'h05, '{8'h63});
    chk(32'({int_out, 4'(n_mon)}), 32'h01);
    chk(32'(ref_input_enable_out), 32'h2);
    rdchk(8'h05, 3, 72'h62205C);
    i_serial_host.wr(7'h69, 8'h00, '{8'h11}, ack);
    chk(32'({ack, prescale_ratio_out}), 32'h002);
    w(8'h08, '{8'hAA});
    rdchk(8'h08, 1, 72'h00);
    w(8'h06, '{8'h10});
    chk(32'({prescale_ratio_out, 4'(n_rst)}), 32'h011);
    rdchk(8'h05, 2, 72'h6000);
    w(8'h00, '{8'h07});
    master_reset_pin_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    master_reset_pin_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    chk(32'(prescale_ratio_out), 32'h1);
    {addr_strap_zero_in, addr_strap_one_in} <= 4'hA;
    rst();
    i_serial_host.spi({1'b0, 7'h00, 8'h7F});
    i_serial_host.spi({1'b1, 7'h04, 8'hA0});
    i_serial_host.spi({1'b0, 7'h04, 8'h80});
    chk(32'({prescale_ratio_out, out_ratio_b_out}), 32'h1005);
    i_serial_host.wr(7'h68, 8'h00, '{8'h01}, ack);
    chk(32'({ack, prescale_ratio_out}), 32'h080);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
